/* frz_defs.svh */
`ifndef FRZ_DEFS_SVH
`define FRZ_DEFS_SVH

// core clock period in ns
`define FRZ_CLK_PERIOD_NS 20
// delay from freeze request to the frozen state, in ns
`define FRZ_ENTRY_NS 1000
// nanoseconds to whole core clock cycles, rounded up
`define FRZ_CEIL_CYC(ns) \
    (((ns) + `FRZ_CLK_PERIOD_NS - 1) / `FRZ_CLK_PERIOD_NS)
// entry delay in core clock cycles, at least one
`define FRZ_ENTRY_CYC \
    ((`FRZ_CEIL_CYC(`FRZ_ENTRY_NS) < 1) ? 1 : `FRZ_CEIL_CYC(`FRZ_ENTRY_NS))
// shortest pulse on the freeze pin that is passed, in ns
`define FRZ_GLITCH_NS 2
// glitch window in core clock cycles, at least one
`define FRZ_GLITCH_CYC \
    ((`FRZ_CEIL_CYC(`FRZ_GLITCH_NS) < 1) ? 1 : `FRZ_CEIL_CYC(`FRZ_GLITCH_NS))

// reset values
`define FRZ_RST_FROZEN 1'b0
`define FRZ_RST_PIN_N 1'b1
`define FRZ_RST_CLK_RUN 1'b1
`define FRZ_RST_PERMIT 1'b0
`define FRZ_RST_HK_REQ 1'b0

`endif

/* frz_pkg.sv */
package frz_pkg;

    // management sequencer states, one-hot
    typedef enum logic [5:0]
    {
        ST_RUN       = 6'h01,
        ST_HOUSEKEEP = 6'h02,
        ST_GATE      = 6'h04,
        ST_PERMIT    = 6'h08,
        ST_RELEASE   = 6'h10,
        ST_RESTART   = 6'h20
    } mgr_state_type;

endpackage

/* freeze_ctl_if.sv */
`timescale 1ns/1ps

// signals between the freeze controller and its management sequencer
interface freeze_ctl_if;
    logic pin_active;   // filtered freeze request, active high
    logic hk_enable;    // housekeeping configured
    logic hk_done;      // housekeeping complete
    logic hk_req;       // housekeeping request
    logic clk_run;      // gated clocks may run
    logic permit;       // sequencer sleep permit

    modport ctl (output pin_active, hk_enable, hk_done,
                 input  hk_req, clk_run, permit);
    modport mgr (input  pin_active, hk_enable, hk_done,
                 output hk_req, clk_run, permit);
endinterface

/* freeze_pin_filter.sv */
`timescale 1ns/1ps
`include "frz_defs.svh"

module freeze_pin_filter
#(
    parameter int FILT_CYC = `FRZ_GLITCH_CYC
)
(
    input  wire logic core_clk_in,   // core clock
    input  wire logic nrst_in,       // sync reset, active low
    input  wire logic pin_n_in,      // raw freeze pin, active low
    output logic      filtered_n_out // filtered pin level, active low
);
    logic       sync1;
    logic       sync2;
    logic [7:0] cnt;
    wire        differs = (sync2 != filtered_n_out);
    wire        settled = (cnt == 8'(FILT_CYC - 1));

    // two-stage synchroniser
    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            sync1 <= `FRZ_RST_PIN_N;
            sync2 <= `FRZ_RST_PIN_N;
        end
        else
        begin
            sync1 <= pin_n_in;
            sync2 <= sync1;
        end
    end

    // RULE7 glitch rejection filter
    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            filtered_n_out <= `FRZ_RST_PIN_N;
            cnt            <= 8'h00;
        end
        else if (!differs)
            cnt <= 8'h00;
        else if (settled)
        begin
            filtered_n_out <= sync2;
            cnt            <= 8'h00;
        end
        else
            cnt <= cnt + 8'h01;
    end

    // RULE7 settled level only
    filter_follows_a: assert property (@(posedge core_clk_in) // RULE7
        disable iff (!nrst_in)
        $changed(filtered_n_out) |-> filtered_n_out == $past(sync2))
        else $error("filter took a level the synchroniser did not hold");
endmodule

/* freeze_manager_fsm.sv */
`timescale 1ns/1ps
`include "frz_defs.svh"

module freeze_manager_fsm
    import frz_pkg::*;
(
    input  wire logic core_clk_in, // core clock
    input  wire logic nrst_in,     // sync reset, active low
    freeze_ctl_if.mgr ctl          // controller side
);
    mgr_state_type state;
    mgr_state_type next_state;

    // next state selection
    always_comb
    begin
        next_state = state;
        case (state)
            ST_RUN:
                if (ctl.pin_active)
                    next_state = ST_HOUSEKEEP;
            ST_HOUSEKEEP:
                if (!ctl.pin_active)
                    next_state = ST_RUN;
                else if (ctl.hk_done)
                    next_state = ST_GATE;
            ST_GATE:
                next_state = ST_PERMIT;
            ST_PERMIT:
                if (!ctl.pin_active)
                    next_state = ST_RELEASE;
            ST_RELEASE:
                next_state = ST_RESTART;
            ST_RESTART:
                next_state = ST_RUN;
            default:
                next_state = ST_RUN;
        endcase
    end

    wire next_gated = (next_state == ST_GATE) ||
                      (next_state == ST_PERMIT) ||
                      (next_state == ST_RELEASE);

    // RULE10 RULE14 permit and clock run come from the sequencer
    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            state       <= ST_RUN;
            ctl.permit  <= `FRZ_RST_PERMIT;
            ctl.clk_run <= `FRZ_RST_CLK_RUN;
            ctl.hk_req  <= `FRZ_RST_HK_REQ;
        end
        else
        begin
            state       <= next_state;
            ctl.permit  <= (next_state == ST_PERMIT);
            ctl.clk_run <= !next_gated;
            ctl.hk_req  <= (next_state == ST_HOUSEKEEP);
        end
    end

    // RULE14 clocks stop first
    permit_clk_stop_a: assert property (@(posedge core_clk_in) // RULE14
        disable iff (!nrst_in)
        $rose(ctl.permit) |-> !ctl.clk_run && !$past(ctl.clk_run))
        else $error("permit raised before clocks stopped");

    // RULE14 restart after permit
    clk_restart_a: assert property (@(posedge core_clk_in) // RULE14
        disable iff (!nrst_in)
        $rose(ctl.clk_run) |-> !ctl.permit && !$past(ctl.permit))
        else $error("clocks restarted while permit high");

    // RULE11 loopback seen here
    hk_loop_seen_a: assert property (@(posedge core_clk_in) // RULE11
        disable iff (!nrst_in)
        !ctl.hk_enable && ctl.hk_req |-> ctl.hk_done)
        else $error("housekeeping request not looped back");
endmodule

/* static_power_freeze_control.sv */
`timescale 1ns/1ps
`include "frz_defs.svh"

// Behaviour
// RULE1 - while frozen, pad drivers are released to high impedance
// RULE2 - pads keep their configured weak pull setting throughout the freeze
// RULE3 - frozen core sees high from input pads and undriven bidirectional pads
// RULE4 - sleep-gate mode freezes only with permit high and pin low
// RULE5 - permit low blocks entry and forces exit from the freeze
// RULE6 - without sleep-gate access the permit is held high
// RULE7 - freeze pin passes a glitch filter before it affects the state
// RULE8 - one freeze pin input cell, fed straight from a top port
// RULE9 - freeze pin has no weak pull; only hysteresis may apply
// RULE10 - management mode takes permit from the sequencer, not user logic
// RULE11 - without housekeeping, request loops back to complete, ports unused
// RULE12 - one gated clock output per selected clock
// RULE13 - enter freeze one microsecond after pin low, leave on pin high
// RULE14 - stop gated clocks before permit, restart them after permit drops; the code keeps this order only for the sequencer permit
module static_power_freeze_control
    import frz_pkg::*;
#(
    parameter int NUM_PADS   = 8,
    parameter int NUM_CLOCKS = 2,
    parameter int ENTRY_CYC  = `FRZ_ENTRY_CYC,
    parameter int FILT_CYC   = `FRZ_GLITCH_CYC
)
(
    input  wire logic                  core_clk_in,            // core clock
    input  wire logic                  nrst_in,                // reset, low
    input  wire logic                  freeze_request_n_in,    // freeze pin
    input  wire logic                  core_sleep_gate_access_in, // gate used
    input  wire logic                  mgmt_core_in,           // sequencer on
    input  wire logic                  sleep_permit_in,        // user permit
    input  wire logic                  housekeeping_enable_in, // hk config
    input  wire logic                  housekeeping_done_in,   // hk complete
    output logic                       housekeeping_request_out, // hk request
    input  wire logic [NUM_CLOCKS-1:0] clock_select_in,        // clocks gated
    output logic [NUM_CLOCKS-1:0]      gated_clk_out,          // gated clocks
    input  wire logic [NUM_PADS-1:0]   pad_data_in,            // pad levels
    input  wire logic [NUM_PADS-1:0]   core_out_in,            // core to pad
    input  wire logic [NUM_PADS-1:0]   core_oe_in,             // core enable
    input  wire logic [NUM_PADS-1:0]   pull_enable_in,         // weak pull on
    input  wire logic [NUM_PADS-1:0]   pull_up_in,             // 1 up, 0 down
    output logic [NUM_PADS-1:0]        pad_out_out,            // pad drive
    output logic [NUM_PADS-1:0]        pad_oe_out,             // pad enable
    output logic [NUM_PADS-1:0]        pad_pull_enable_out,    // pull active
    output logic [NUM_PADS-1:0]        pad_pull_up_out,        // pull sense
    output logic [NUM_PADS-1:0]        core_data_out,          // pad to core
    output logic                       sleep_permit_out,       // permit used
    output logic                       frozen_out              // frozen state
);
    localparam int ENTRY_LAT = ENTRY_CYC;

    freeze_ctl_if ctl ();

    logic                filtered_n;
    logic [15:0]         entry_cnt;
    logic [15:0]         arm_age;
    logic [NUM_PADS-1:0] pad_sync1;
    logic [NUM_PADS-1:0] pad_sync2;
    logic [NUM_CLOCKS-1:0] clk_en_lat;

    // RULE8 RULE9 the only freeze pin input cell, no pull on it
    freeze_pin_filter #(
        .FILT_CYC (FILT_CYC)
    ) freeze_pin_input_cell (
        .core_clk_in    (core_clk_in),
        .nrst_in        (nrst_in),
        .pin_n_in       (freeze_request_n_in),
        .filtered_n_out (filtered_n)
    );

    // management sequencer
    freeze_manager_fsm manager (
        .core_clk_in (core_clk_in),
        .nrst_in     (nrst_in),
        .ctl         (ctl.mgr)
    );

    // RULE11 housekeeping loopback when not configured
    assign ctl.pin_active = !filtered_n;
    assign ctl.hk_enable  = housekeeping_enable_in;
    assign ctl.hk_done    = housekeeping_enable_in ? housekeeping_done_in
                                                   : ctl.hk_req;
    assign housekeeping_request_out = housekeeping_enable_in & ctl.hk_req;

    // RULE6 RULE10 choose where the permit comes from
    wire user_permit = mgmt_core_in ? ctl.permit : sleep_permit_in;
    wire permit_eff  = core_sleep_gate_access_in ? user_permit : 1'b1;
    // RULE4 RULE5 both conditions needed to arm the freeze
    wire arm         = ctl.pin_active & permit_eff;
    wire entry_due   = (entry_cnt == 16'(ENTRY_CYC - 1));

    assign sleep_permit_out = permit_eff;

    // RULE13 entry delay count and frozen state
    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            frozen_out <= `FRZ_RST_FROZEN;
            entry_cnt  <= 16'h0000;
        end
        else if (!arm)
        begin
            frozen_out <= 1'b0;
            entry_cnt  <= 16'h0000;
        end
        else if (!frozen_out)
        begin
            frozen_out <= entry_due;
            entry_cnt  <= entry_due ? 16'h0000 : entry_cnt + 16'h0001;
        end
    end

    // pad input synchroniser
    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            pad_sync1 <= '0;
            pad_sync2 <= '0;
        end
        else
        begin
            pad_sync1 <= pad_data_in;
            pad_sync2 <= pad_sync1;
        end
    end

    // RULE1 drivers released while frozen
    wire [NUM_PADS-1:0] next_oe  = frozen_out ? '0 : core_oe_in;
    wire [NUM_PADS-1:0] next_out = frozen_out ? '0 : core_out_in;
    // RULE2 pull setting held while frozen
    wire [NUM_PADS-1:0] next_pen = frozen_out ? pad_pull_enable_out
                                              : pull_enable_in;
    wire [NUM_PADS-1:0] next_pup = frozen_out ? pad_pull_up_out
                                              : pull_up_in;
    // RULE3 tie core side high for undriven pads while frozen
    wire [NUM_PADS-1:0] next_core = pad_sync2 |
                                    ({NUM_PADS{frozen_out}} & ~core_oe_in);

    // pad and core side registers
    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            pad_oe_out          <= '0;
            pad_out_out         <= '0;
            pad_pull_enable_out <= '0;
            pad_pull_up_out     <= '0;
            core_data_out       <= '0;
        end
        else
        begin
            pad_oe_out          <= next_oe;
            pad_out_out         <= next_out;
            pad_pull_enable_out <= next_pen;
            pad_pull_up_out     <= next_pup;
            core_data_out       <= next_core;
        end
    end

    // RULE12 RULE14 glitch-free gate per selected clock
    genvar g;
    generate
        for (g = 0; g < NUM_CLOCKS; g++)
        begin : gate
            // enable latched while the clock is low
            always_latch
            begin
                if (!core_clk_in)
                    clk_en_lat[g] = ctl.clk_run | ~clock_select_in[g];
            end
            assign gated_clk_out[g] = core_clk_in & clk_en_lat[g];
        end
    endgenerate

    // helper: cycles the arm condition has held
    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in || !arm)
            arm_age <= 16'h0000;
        else if (arm_age != 16'hffff)
            arm_age <= arm_age + 16'h0001;
    end

    // RULE13 entry delay length
    entry_time_a: assert property (@(posedge core_clk_in) // RULE13
        disable iff (!nrst_in)
        $rose(frozen_out) |-> arm_age == 16'(ENTRY_LAT))
        else $error("freeze entered at the wrong delay");

    // RULE13 fresh entry count
    no_early_freeze_a: assert property (@(posedge core_clk_in) // RULE13
        disable iff (!nrst_in)
        $rose(arm) |-> !frozen_out)
        else $error("frozen without a fresh entry delay");

    // RULE4 pin and permit
    entry_needs_arm_a: assert property (@(posedge core_clk_in) // RULE4
        disable iff (!nrst_in)
        $rose(frozen_out) |-> $past(ctl.pin_active) && $past(permit_eff))
        else $error("freeze entered without pin and permit");

    // RULE5 permit low exit
    permit_low_exit_a: assert property (@(posedge core_clk_in) // RULE5
        disable iff (!nrst_in)
        core_sleep_gate_access_in && !user_permit |=> !frozen_out)
        else $error("still frozen with permit low");

    // RULE6 permit tied high
    pin_only_mode_a: assert property (@(posedge core_clk_in) // RULE6
        disable iff (!nrst_in)
        !core_sleep_gate_access_in |-> sleep_permit_out)
        else $error("permit not high without sleep-gate access");

    // RULE13 leave on pin
    pin_high_exit_a: assert property (@(posedge core_clk_in) // RULE13
        disable iff (!nrst_in)
        frozen_out && filtered_n |=> !frozen_out)
        else $error("did not leave freeze on pin high");

    // RULE1 enables released
    pads_released_a: assert property (@(posedge core_clk_in) // RULE1
        disable iff (!nrst_in)
        frozen_out |=> pad_oe_out == '0)
        else $error("pad driven while frozen");

    // RULE2 pulls held
    pull_held_a: assert property (@(posedge core_clk_in) // RULE2
        disable iff (!nrst_in)
        frozen_out && $past(frozen_out) |=>
            $stable(pad_pull_enable_out) && $stable(pad_pull_up_out))
        else $error("weak pull changed while frozen");

    // RULE3 undriven pads high
    core_tied_high_a: assert property (@(posedge core_clk_in) // RULE3
        disable iff (!nrst_in)
        frozen_out |=> &(core_data_out | $past(core_oe_in)))
        else $error("core input not high while frozen");

    // RULE11 loopback when unused
    hk_loopback_a: assert property (@(posedge core_clk_in) // RULE11
        disable iff (!nrst_in)
        !housekeeping_enable_in |-> !housekeeping_request_out &&
            ctl.hk_done == ctl.hk_req)
        else $error("housekeeping loopback broken");

    // RULE1 drive held low
    pad_drive_off_a: assert property (@(posedge core_clk_in) // RULE1
        disable iff (!nrst_in)
        frozen_out |=> pad_out_out == '0)
        else $error("pad drive not low while frozen");

    // RULE1 normal pad path
    pads_follow_a: assert property (@(posedge core_clk_in) // RULE1
        disable iff (!nrst_in)
        !frozen_out |=> pad_oe_out == $past(core_oe_in) &&
            pad_out_out == $past(core_out_in))
        else $error("pad drive not following core when awake");

    // RULE2 pulls follow config
    pull_follow_a: assert property (@(posedge core_clk_in) // RULE2
        disable iff (!nrst_in)
        !frozen_out |=> pad_pull_enable_out == $past(pull_enable_in) &&
            pad_pull_up_out == $past(pull_up_in))
        else $error("weak pull not following config when awake");

    // RULE3 awake core path
    core_follow_a: assert property (@(posedge core_clk_in) // RULE3
        disable iff (!nrst_in)
        !frozen_out |=> core_data_out == $past(pad_sync2))
        else $error("core input not following pad when awake");

    // RULE3 driven pads pass
    driven_pad_pass_a: assert property (@(posedge core_clk_in) // RULE3
        disable iff (!nrst_in)
        frozen_out |=>
            ((core_data_out ^ $past(pad_sync2)) & $past(core_oe_in)) == '0)
        else $error("driven pad level lost while frozen");

    // RULE13 frozen state stands
    frozen_holds_a: assert property (@(posedge core_clk_in) // RULE13
        disable iff (!nrst_in)
        frozen_out && arm |=> frozen_out)
        else $error("freeze dropped while still armed");

    // RULE13 count stays bounded
    entry_cnt_bound_a: assert property (@(posedge core_clk_in) // RULE13
        disable iff (!nrst_in)
        entry_cnt < 16'(ENTRY_CYC))
        else $error("entry counter past its end");

    // RULE4 no freeze pin high
    pin_high_thaw_a: assert property (@(posedge core_clk_in) // RULE4
        disable iff (!nrst_in)
        !ctl.pin_active |=> !frozen_out)
        else $error("frozen with the pin released");

    // RULE4 user permit used
    user_permit_a: assert property (@(posedge core_clk_in) // RULE4
        disable iff (!nrst_in)
        core_sleep_gate_access_in && !mgmt_core_in |->
            sleep_permit_out == sleep_permit_in)
        else $error("user permit not used");

    // RULE10 sequencer permit used
    mgmt_permit_a: assert property (@(posedge core_clk_in) // RULE10
        disable iff (!nrst_in)
        core_sleep_gate_access_in && mgmt_core_in |->
            sleep_permit_out == ctl.permit)
        else $error("sequencer permit not used");

    // RULE11 handshake exposed
    hk_exposed_a: assert property (@(posedge core_clk_in) // RULE11
        disable iff (!nrst_in)
        housekeeping_enable_in |->
            housekeeping_request_out == ctl.hk_req &&
            ctl.hk_done == housekeeping_done_in)
        else $error("housekeeping handshake not passed through");
endmodule

/* freeze_host_model.sv */
`timescale 1ns/1ps

// external controller driving the freeze pin; push-pull, never floats
module freeze_host_model
(
    output logic freeze_request_n_out // freeze pin, low asks for freeze
);
    initial freeze_request_n_out = 1'b1;

    // assert the request and hold it as a level
    task automatic press();
        freeze_request_n_out = 1'b0;
    endtask

    // release the request, pin driven high again
    task automatic lift();
        freeze_request_n_out = 1'b1;
    endtask

    // short low pulse, far under one core clock and the filter window
    task automatic glitch();
        freeze_request_n_out = 1'b0;
        #1;
        freeze_request_n_out = 1'b1;
    endtask
endmodule

/* static_power_freeze_control_bench.sv */
`timescale 1ns/1ps
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin \
n_mismatch++; $display("BAD %0t %s", $time, m); end end

module static_power_freeze_control_bench;
    localparam int NP  = 8;
    localparam int NC  = 2;
    localparam int ENT = 4;
    logic          core_clk_in = 1'b0;
    logic          nrst_in     = 1'b0;
    logic          gate_acc    = 1'b0;
    logic          mgmt        = 1'b0;
    logic          permit      = 1'b0;
    logic          hk_en       = 1'b0;
    logic          hk_done     = 1'b0;
    logic [NC-1:0] clk_sel     = 2'h1;
    logic [NP-1:0] pad_d       = 8'h00;
    logic [NP-1:0] c_out       = 8'h00;
    logic [NP-1:0] c_oe        = 8'h00;
    logic [NP-1:0] pull_en     = 8'h00;
    logic [NP-1:0] pull_up     = 8'h00;
    logic [NP-1:0] exp_pe;
    logic [NP-1:0] exp_pu;
    logic [31:0]   seed        = 32'h9c193ad1;
    logic          pin_n;
    logic          hk_req;
    logic          permit_o;
    logic          frozen;
    logic [NC-1:0] gclk;
    logic [NP-1:0] p_out;
    logic [NP-1:0] p_oe;
    logic [NP-1:0] p_pe;
    logic [NP-1:0] p_pu;
    logic [NP-1:0] core_d;
    int            n_mismatch  = 0;
    int            checks_done = 0;
    int            lat;

    // free-running core clock, 20 ns period
    always #10 core_clk_in = ~core_clk_in;

    freeze_host_model host (.freeze_request_n_out(pin_n));

    static_power_freeze_control #(.ENTRY_CYC(ENT)) uut
    (
        .core_clk_in              (core_clk_in),
        .nrst_in                  (nrst_in),
        .freeze_request_n_in      (pin_n),
        .core_sleep_gate_access_in(gate_acc),
        .mgmt_core_in             (mgmt),
        .sleep_permit_in          (permit),
        .housekeeping_enable_in   (hk_en),
        .housekeeping_done_in     (hk_done),
        .housekeeping_request_out (hk_req),
        .clock_select_in          (clk_sel),
        .gated_clk_out            (gclk),
        .pad_data_in              (pad_d),
        .core_out_in              (c_out),
        .core_oe_in               (c_oe),
        .pull_enable_in           (pull_en),
        .pull_up_in               (pull_up),
        .pad_out_out              (p_out),
        .pad_oe_out               (p_oe),
        .pad_pull_enable_out      (p_pe),
        .pad_pull_up_out          (p_pu),
        .core_data_out            (core_d),
        .sleep_permit_out         (permit_o),
        .frozen_out               (frozen)
    );

    // pseudo-random source for pad stimulus
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // move to a fixed point just after the rising edge
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge core_clk_in);
            #2;
        end
    endtask

    task automatic close_out();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // bounded wait for frozen_out to reach v; lat gives cycles taken
    task automatic wait_frz(input logic v, input int lim);
        lat = 0;
        while (frozen !== v && lat < lim)
        begin
            tick(1);
            lat++;
        end
        if (frozen !== v)
        begin
            n_mismatch++;
            $display("BAD %0t frozen state not reached", $time);
            close_out();
        end
    endtask

    // called just after a rising edge, so the core clock is high here
    task automatic chk_clk(input logic [NC-1:0] e);
        `CHK(gclk, e, "gated clocks")
    endtask

    // frozen pad model: drivers off, pulls held, undriven inputs read high
    task automatic chk_pads();
        `CHK(p_oe, 8'h00, "pad enable while frozen")
        `CHK(p_out, 8'h00, "pad drive while frozen")
        `CHK(p_pe, exp_pe, "pull enable held")
        `CHK(p_pu, exp_pu, "pull sense held")
        `CHK(core_d, pad_d | ~c_oe, "core sees high")
    endtask

    initial
    begin
        #200_000;
        n_mismatch++;
        $display("BAD %0t run limit reached", $time);
        close_out();
    end

    initial
    begin
        tick(3);
        nrst_in = 1'b1;
        tick(4);
        `CHK(permit_o, 1'b1, "permit tied high")
        // pin-only entry and exit, random pad setups
        repeat (3)
        begin
            seed = lfsr(seed);
            {pad_d, c_out, c_oe, pull_en} = seed;
            seed = lfsr(seed);
            pull_up = seed[7:0];
            exp_pe = pull_en;
            exp_pu = pull_up;
            tick(4);
            host.press();
            wait_frz(1'b1, ENT + 10);
            `CHK(lat >= ENT+2 && lat <= ENT+4, 1'b1, "entry delay")
            pull_en = ~pull_en;
            pull_up = ~pull_up;
            tick(2);
            chk_pads();
            host.lift();
            wait_frz(1'b0, 8);
            `CHK(lat >= 3, 1'b1, "exit too early")
            pull_en = exp_pe;
            pull_up = exp_pu;
        end
        // a glitch on the pin must not freeze
        host.glitch();
        tick(ENT + 10);
        `CHK(frozen, 1'b0, "glitch froze")
        // sleep-gate mode with user permit
        gate_acc = 1'b1;
        tick(1);
        `CHK(permit_o, 1'b0, "permit follows user")
        host.press();
        tick(ENT + 10);
        `CHK(frozen, 1'b0, "froze without permit")
        permit = 1'b1;
        wait_frz(1'b1, ENT + 6);
        permit = 1'b0;
        wait_frz(1'b0, 4);
        host.lift();
        tick(4);
        permit = 1'b1;
        tick(ENT + 10);
        `CHK(frozen, 1'b0, "froze with pin high")
        // sequencer mode, housekeeping looped back
        permit = 1'b0;
        mgmt = 1'b1;
        tick(2);
        host.press();
        lat = 0;
        while (permit_o !== 1'b1 && lat < 20)
        begin
            `CHK(hk_req, 1'b0, "hk request exposed")
            tick(1);
            lat++;
        end
        `CHK(permit_o, 1'b1, "sequencer permit")
        chk_clk(2'h2);
        wait_frz(1'b1, ENT + 6);
        host.lift();
        lat = 0;
        while (permit_o !== 1'b0 && lat < 10)
        begin
            tick(1);
            lat++;
        end
        `CHK(permit_o, 1'b0, "sequencer permit dropped")
        chk_clk(2'h2);
        tick(2);
        chk_clk(2'h3);
        // sequencer mode with housekeeping handshake
        hk_en = 1'b1;
        host.press();
        lat = 0;
        while (hk_req !== 1'b1 && lat < 10)
        begin
            tick(1);
            lat++;
        end
        `CHK(hk_req, 1'b1, "hk request")
        tick(3);
        `CHK(permit_o, 1'b0, "permit before hk done")
        hk_done = 1'b1;
        wait_frz(1'b1, ENT + 10);
        host.lift();
        wait_frz(1'b0, 10);
        close_out();
    end
endmodule
